// [shared/dax_pkg.sv]
// Purpose: constants and carrier types for the dual-axis acceleration sensor serial port
// Assumes: one core clock of 20 MHz samples every pin of the serial link
// Notes: the serial clock is sampled and its edges found in the core clock domain
//
// Overview of operation
// - temperature select, active low, frames every temperature read for its whole length
// - the first output bit is driven at select fall, each later one onto the serial output at a serial clock fall
// - serial input bits enter the control word at serial clock rises
// - self test raises the acceleration code by typically 614 codes
// - falling acceleration select starts a conversion and frames its transfer
// - the serial clock both shifts data and paces the conversion
// - five wires: two selects share clock, serial input and serial output
// - acceleration is sampled on the second serial clock rise after select falls
// - a conversion takes 16 serial clocks; the host supplies all 16
// - rising acceleration select puts the serial output into high impedance
// - select held low after 16 clocks starts the next conversion at once
// - control bit 3 picks the axis: zero for X, one for Y
// - control bit 0 picks the mode: zero normal, one power-down
// - control contents are kept while powered down
// - power-down takes effect as soon as the control update completes
// - waking from power-down happens on the sixteenth serial clock rise of that frame
// - a temperature read is 16 clocks returning a leading zero then ten bits
// - after a temperature read the last bit holds until temperature select rises

package dax_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned IGNORED_POS = 7;
  localparam int unsigned AXIS_POS = 3;
  localparam int unsigned POWER_POS = 0;
  localparam logic [7:0] CTRL_RESET = 8'h04;

  // ----------------------------------------------------------------
  // frame counts, as rises already seen when the named rise arrives
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_RISE = 4'h1;
  localparam logic [3:0] LOAD_RISE = 4'h2;
  localparam logic [3:0] CTRL_LAST_RISE = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'hf;
  localparam logic [3:0] TEMP_LAST_IDX = 4'ha;

  // ----------------------------------------------------------------
  // data widths and values
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W = 12;
  localparam int unsigned TEMP_W = 10;
  localparam logic [12:0] SELF_TEST_SHIFT = 13'h266;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [9:0] TEMP_RESET = 10'h000;
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic axis;
    logic [CODE_W-1:0] code;
  } dax_sample_t;

  typedef struct packed {
    logic sclk;
    logic accelSelN;
    logic tempSelN;
    logic din;
    logic selfTest;
  } dax_pins_t;

  localparam dax_pins_t PINS_IDLE = 5'b01100;

endpackage

// [logic/dax_fifo.sv]
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: data out comes straight from the storage array at the read pointer
`timescale 1ns/1ps
`default_nettype none

module dax_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic full, empty, doWrite, doRead;

  assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty = (wrPtr_q == rdPtr_q);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign doWrite = inValid && !full;
  assign doRead = outReady && !empty;

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (doWrite) begin
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (doRead) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

endmodule

`default_nettype wire

// [logic/dax_serial_port.sv]
// Purpose: serial slave port of a dual-axis acceleration sensor with temperature select
// Assumes: core_clk at 20 MHz, serial clock at most 2.5 MHz so each level lasts 4+ cycles
// Notes: all pins pass a two-flop synchroniser; output lags pin edges by about 3 cycles
`timescale 1ns/1ps
`default_nettype none

module dax_serial_port
  import dax_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // serial link pins
  input wire logic sclk,
  input wire logic accelSelN,
  input wire logic temp_select_n,
  input wire logic din,
  output logic dout,
  output logic doutOe,
  // sensor side
  input wire logic self_test_in,
  input wire logic [CODE_W-1:0] xCode,
  input wire logic [CODE_W-1:0] yCode,
  input wire logic [TEMP_W-1:0] tempCode,
  // control state towards the analog front end
  output logic axis_select,
  output logic powerDown,
  output logic [CTRL_W-1:0] accelControl
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic accelBit(input logic [CODE_W-1:0] code, input logic [3:0] idx);
    logic [15:0] word;
    word = {4'h0, code};
    return word[4'hf - idx];
  endfunction

  // leading zero then ten bits; the last bit stays once the read is over
  function automatic logic tempBit(input logic [TEMP_W-1:0] code, input logic [3:0] idx);
    logic [10:0] word;
    logic [3:0] sat;
    word = {1'b0, code};
    sat = (idx > TEMP_LAST_IDX) ? TEMP_LAST_IDX : idx;
    return word[TEMP_LAST_IDX - sat];
  endfunction

  function automatic logic [CODE_W-1:0] addSelfTest(input logic [CODE_W-1:0] code);
    logic [12:0] sum;
    sum = {1'b0, code} + SELF_TEST_SHIFT;
    return sum[12] ? CODE_MAX : sum[CODE_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser and edge detection
  // ----------------------------------------------------------------
  dax_pins_t pinsA_q, pinsA_d, pinsB_q, pinsB_d, prev_q, prev_d, pinsRaw;
  logic sclkRise, sclkFall, accelFall, tempFall, accelActive, tempActive;

  assign pinsRaw = '{sclk: sclk, accelSelN: accelSelN, tempSelN: temp_select_n,
                     din: din, selfTest: self_test_in};

  // only the second and third stages are ever judged, so a metastable first stage never reaches logic
  always_comb begin
    pinsA_d = pinsRaw;
    pinsB_d = pinsA_q;
    prev_d = pinsB_q;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinsA_q <= PINS_IDLE;
      pinsB_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      pinsA_q <= pinsA_d;
      pinsB_q <= pinsB_d;
      prev_q <= prev_d;
    end
  end

  // ----------------------------------------------------------------
  // edge detection on the settled pin copies
  // ----------------------------------------------------------------
  assign sclkRise = pinsB_q.sclk && !prev_q.sclk;
  assign sclkFall = !pinsB_q.sclk && prev_q.sclk;
  assign accelFall = !pinsB_q.accelSelN && prev_q.accelSelN;
  // acceleration select wins if the host breaks the exclusivity
  assign accelActive = !pinsB_q.accelSelN;
  assign tempActive = !pinsB_q.tempSelN && !accelActive;
  assign tempFall = tempActive && prev_q.tempSelN;

  // ----------------------------------------------------------------
  // frame position: rises seen since the select fell
  // ----------------------------------------------------------------
  logic [3:0] riseCnt_q, riseCnt_d;

  always_comb begin
    riseCnt_d = riseCnt_q;
    if (accelFall || tempFall) begin
      riseCnt_d = 4'h0;
    end else if (sclkRise && accelActive) begin
      // wraps after the sixteenth rise so a held select starts the next conversion
      riseCnt_d = riseCnt_q + 4'h1;
    end else if (sclkRise && tempActive && riseCnt_q != FRAME_LAST) begin
      riseCnt_d = riseCnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      riseCnt_q <= 4'h0;
    end else begin
      riseCnt_q <= riseCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // control word and power mode
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrlShift_q, ctrlShift_d, ctrl_q, ctrl_d, newWord;
  logic pd_q, pd_d, wake_q, wake_d;
  logic accelRise, ctrlUpdate, frameEnd;

  assign accelRise = accelActive && sclkRise;
  assign newWord = {ctrlShift_q[CTRL_W-2:0], pinsB_q.din};
  assign ctrlUpdate = accelRise && riseCnt_q == CTRL_LAST_RISE;
  assign frameEnd = accelRise && riseCnt_q == FRAME_LAST;

  always_comb begin
    ctrlShift_d = ctrlShift_q;
    ctrl_d = ctrl_q;
    pd_d = pd_q;
    wake_d = wake_q;
    if (accelRise && riseCnt_q <= CTRL_LAST_RISE) begin
      ctrlShift_d = newWord;
    end
    if (ctrlUpdate) begin
      ctrl_d = newWord;
      ctrl_d[IGNORED_POS] = 1'b0;
      if (newWord[POWER_POS]) begin
        // shutdown takes effect at once
        pd_d = 1'b1;
        wake_d = 1'b0;
      end else if (pd_q) begin
        wake_d = 1'b1;
      end
    end
    // a pending wake outlives an aborted frame and completes on a later one
    if (wake_q && frameEnd) begin
      pd_d = 1'b0;
      wake_d = 1'b0;
    end
  end

  // contents are only ever replaced by a write, never by shutdown
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlShift_q <= CTRL_RESET;
      ctrl_q <= CTRL_RESET;
      pd_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      ctrlShift_q <= ctrlShift_d;
      ctrl_q <= ctrl_d;
      pd_q <= pd_d;
      wake_q <= wake_d;
    end
  end

  assign accelControl = ctrl_q;
  assign axis_select = ctrl_q[AXIS_POS];
  assign powerDown = pd_q;

  // ----------------------------------------------------------------
  // sampling into the result FIFO
  // ----------------------------------------------------------------
  dax_sample_t pend_q, pend_d, headSample;
  logic pendValid_q, pendValid_d, fifoInReady, fifoOutValid, popReq;
  logic [CODE_W-1:0] baseCode;

  assign baseCode = ctrl_q[AXIS_POS] ? yCode : xCode;

  always_comb begin
    pend_d = pend_q;
    pendValid_d = pendValid_q;
    if (pendValid_q && fifoInReady) begin
      pendValid_d = 1'b0;
    end
    // a sample that finds the FIFO full waits here and blocks the next one
    if (accelRise && riseCnt_q == SAMPLE_RISE && !pd_q && !pendValid_d) begin
      pendValid_d = 1'b1;
      pend_d.axis = ctrl_q[AXIS_POS];
      pend_d.code = pinsB_q.selfTest ? addSelfTest(baseCode) : baseCode;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= '0;
      pendValid_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      pendValid_q <= pendValid_d;
    end
  end

  assign popReq = accelActive && sclkFall && riseCnt_q == LOAD_RISE;

  dax_fifo #(
    .WIDTH($bits(dax_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) resultFifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .inValid(pendValid_q),
    .inReady(fifoInReady),
    .inData(pend_q),
    .outValid(fifoOutValid),
    .outReady(popReq),
    .outData(headSample)
  );

  // ----------------------------------------------------------------
  // link ownership
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LINK_IDLE, LINK_ACCEL, LINK_TEMP} dax_link_t;
  dax_link_t link_q, link_d;

  always_comb begin
    link_d = link_q;
    unique case (link_q)
      LINK_IDLE: begin
        if (accelActive) begin
          link_d = LINK_ACCEL;
        end else if (tempActive) begin
          link_d = LINK_TEMP;
        end
      end
      LINK_ACCEL: begin
        if (!accelActive) begin
          link_d = tempActive ? LINK_TEMP : LINK_IDLE;
        end
      end
      LINK_TEMP: begin
        // a host that breaks exclusivity loses the temperature frame
        if (accelActive) begin
          link_d = LINK_ACCEL;
        end else if (!tempActive) begin
          link_d = LINK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_q <= LINK_IDLE;
    end else begin
      link_q <= link_d;
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] outCode_q, outCode_d;
  logic [TEMP_W-1:0] tempLatch_q, tempLatch_d;
  logic dout_q, dout_d, oe_q, oe_d;

  always_comb begin
    outCode_d = outCode_q;
    tempLatch_d = tempLatch_q;
    dout_d = dout_q;
    if (popReq && fifoOutValid) begin
      outCode_d = headSample.code;
    end
    if (tempFall) begin
      tempLatch_d = tempCode;
    end
    if (accelFall) begin
      dout_d = accelBit(outCode_q, 4'h0);
    end else if (accelActive && sclkFall) begin
      dout_d = accelBit(outCode_d, riseCnt_q);
    end else if (tempFall) begin
      dout_d = tempBit(tempCode, 4'h0);
    end else if (tempActive && sclkFall) begin
      dout_d = tempBit(tempLatch_q, riseCnt_q);
    end
    // driver released as soon as the owning select rises
    oe_d = (link_d != LINK_IDLE);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outCode_q <= CODE_RESET;
      tempLatch_q <= TEMP_RESET;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      outCode_q <= outCode_d;
      tempLatch_q <= tempLatch_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign dout = dout_q;
  assign doutOe = oe_q;

endmodule

`default_nettype wire

// [test/dax_checker.sv]
// Purpose: concurrent checks on the serial port pins and control state
// Assumes: one core clock domain, host keeps sclk levels at 4 core cycles or more
// Notes: pin events reach the outputs after a few core cycles of synchronising
`timescale 1ns/1ps
`default_nettype none

module dax_checker
  import dax_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // serial link pins
  input wire logic sclk,
  input wire logic accelSelN,
  input wire logic temp_select_n,
  input wire logic dout,
  input wire logic doutOe,
  // control state
  input wire logic axis_select,
  input wire logic powerDown,
  input wire logic [CTRL_W-1:0] accelControl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // link steps
  // ----------------------------------------------------------------
  sequence accelFall;
    $fell(accelSelN) && temp_select_n;
  endsequence
  sequence tempFall;
    $fell(temp_select_n) && accelSelN;
  endsequence
  sequence idleBoth;
    (accelSelN && temp_select_n) [*6];
  endsequence
  sequence ctrlWrite;
    $changed(accelControl);
  endsequence

  oe_on_a: assert property (accelFall |-> ##[1:5] doutOe)
    else $error("output not enabled after acceleration select fall");
  temp_on_a: assert property (tempFall |-> ##[1:5] doutOe)
    else $error("output not enabled after temperature select fall");
  oe_off_a: assert property ($rose(accelSelN) && temp_select_n |-> ##[1:5] !doutOe)
    else $error("output still enabled after select rise");
  idle_off_a: assert property (idleBoth |-> !doutOe)
    else $error("output enabled with both selects high");
  dout_fall_a: assert property (sclk [*4] |-> $stable(dout))
    else $error("serial output moved while serial clock high");
  ctrl_map_a: assert property (!accelControl[IGNORED_POS] && axis_select == accelControl[AXIS_POS])
    else $error("control word fields inconsistent");
  ctrl_rise_a: assert property (ctrlWrite |-> sclk && !accelSelN)
    else $error("control word changed outside a clock rise of a frame");
  pd_enter_a: assert property (ctrlWrite ##0 accelControl[POWER_POS] |-> ##[0:1] powerDown)
    else $error("power-down not entered after write");
  wake_a: assert property ($fell(powerDown) |-> sclk && !accelSelN && !accelControl[POWER_POS])
    else $error("wake outside a clock rise of a frame");
endmodule

bind dax_serial_port dax_checker u_chk (
  .core_clk(core_clk),
  .nrst(nrst),
  .sclk(sclk),
  .accelSelN(accelSelN),
  .temp_select_n(temp_select_n),
  .dout(dout),
  .doutOe(doutOe),
  .axis_select(axis_select),
  .powerDown(powerDown),
  .accelControl(accelControl)
);
`default_nettype wire

// [test/dax_host_model.sv]
// Purpose: host master that frames transfers on the serial link
// Assumes: link levels last 4 core cycles, so sclk runs with a 400 ns period
// Notes: a released output line shows a toggling pattern, never the last bit
`timescale 1ns/1ps
`default_nettype none

module dax_host_model (
  // clock
  input wire logic core_clk,
  // link towards the device
  output logic sclk,
  output logic accelSelN,
  output logic temp_select_n,
  output logic din,
  input wire logic dout,
  input wire logic doutOe
);
  logic lineLast;
  logic sdoLine;

  initial begin
    sclk = 1'b0;
    accelSelN = 1'b1;
    temp_select_n = 1'b1;
    din = 1'b0;
    lineLast = 1'b0;
  end

  assign sdoLine = doutOe ? dout : ~lineLast;
  always @(posedge core_clk) begin
    lineLast <= sdoLine;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // one framed transfer; output sampled late in the high phase
  // ----------------------------------------------------------------
  task automatic frame(input logic accel, input logic [7:0] ctrl, input int conv,
                       output logic [31:0] bits);
    int k;
    bits = '0;
    wait_cyc(1);
    if (accel) begin
      accelSelN = 1'b0;
    end else begin
      temp_select_n = 1'b0;
    end
    for (k = 0; k < 16 * conv; k++) begin
      din = (accel && (k % 16) < 8) ? ctrl[7 - (k % 16)] : 1'b0;
      wait_cyc(4);
      sclk = 1'b1;
      wait_cyc(4);
      bits = {bits[30:0], sdoLine};
      sclk = 1'b0;
    end
    wait_cyc(4);
    accelSelN = 1'b1;
    temp_select_n = 1'b1;
    // spacing keeps the sample rate under the filter recovery limit
    wait_cyc(1900);
  endtask
endmodule
`default_nettype wire

// [test/test_dual_axis_accel_serial_port.sv]
// Purpose: self-checking bench for the serial port through framed host transfers
// Assumes: bench drives sensor codes directly, 1 ns after the clock edge
// Notes: each frame returns {4'h0, code}; a temperature read pads with its lsb
`timescale 1ns/1ps
`default_nettype none

module test_dual_axis_accel_serial_port;
  import dax_pkg::*;
  logic core_clk, nrst, sclk, accelSelN, temp_select_n, din, self_test_in;
  logic dout, doutOe, axis_select, powerDown;
  logic [CODE_W-1:0] xCode, yCode;
  logic [TEMP_W-1:0] tempCode;
  logic [CTRL_W-1:0] accelControl;
  logic [31:0] got;
  int mismatches, n_checks;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  dax_serial_port DUT (.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .accelSelN(accelSelN),
    .temp_select_n(temp_select_n), .din(din), .dout(dout), .doutOe(doutOe),
    .self_test_in(self_test_in), .xCode(xCode), .yCode(yCode), .tempCode(tempCode),
    .axis_select(axis_select), .powerDown(powerDown), .accelControl(accelControl));

  dax_host_model host (.core_clk(core_clk), .sclk(sclk), .accelSelN(accelSelN),
    .temp_select_n(temp_select_n), .din(din), .dout(dout), .doutOe(doutOe));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic acc(input logic [7:0] ctrl, input logic [11:0] code);
    host.frame(1'b1, ctrl, 1, got);
    check(got[15:0], {4'h0, code});
    $display("test frame %h done", ctrl);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    self_test_in = 1'b0;
    xCode = 12'h123;
    yCode = 12'hf00;
    tempCode = 10'h2c9;
    repeat (16) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(16'(accelControl), 16'h0004);
    check(16'({axis_select, powerDown, doutOe}), 16'h0000);
    $display("test reset done");
    acc(8'h8c, xCode);
    check(16'(accelControl), 16'h000c);
    check(16'(axis_select), 16'h0001);
    acc(8'h04, yCode);
    self_test_in = 1'b1;
    acc(8'h0c, xCode + 12'h266);
    acc(8'h04, CODE_MAX);
    self_test_in = 1'b0;
    host.frame(1'b1, 8'h04, 2, got);
    check(got[31:16], {4'h0, xCode});
    check(got[15:0], {4'h0, xCode});
    $display("test back to back done");
    acc(8'h05, xCode);
    check(16'(powerDown), 16'h0001);
    xCode = 12'h456;
    acc(8'h05, 12'h123);
    check(16'(accelControl), 16'h0005);
    acc(8'h04, 12'h123);
    check(16'(powerDown), 16'h0000);
    acc(8'h04, xCode);
    host.frame(1'b0, 8'h00, 1, got);
    check(got[15:0], {1'b0, tempCode, {5{tempCode[0]}}});
    check(16'(accelControl), 16'h0004);
    check(16'(doutOe), 16'h0000);
    $display("test temperature done");
    close_out();
  end

  initial begin
    #3000000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
